// File: rtl/gpf_gpio_top.sv
`timescale 1ns/1ps
`default_nettype none

module gpf_gpio_top
	import gpf_pkg::*;
#(
	parameter int STARTUP_CLKS = gpf_pkg::STARTUP_OSC_CLKS
) (
	input  wire logic                                      clk_sys,
	input  wire logic                                      reset_n,
	input  wire logic                                      osc_clk_tick,
	input  wire logic                                      strap_reset,
	input  wire logic [gpf_pkg::NUM_PINS*gpf_pkg::CFG_WIDTH-1:0] cfg_wdata,
	input  wire logic [gpf_pkg::NUM_PORTS-1:0]             cfg_we,
	input  wire logic [gpf_pkg::NUM_PINS-1:0]              out_wdata,
	input  wire logic [gpf_pkg::NUM_PORTS-1:0]             out_we,
	input  wire logic [gpf_pkg::NUM_PINS-1:0]              set_wdata,
	input  wire logic [gpf_pkg::NUM_PORTS-1:0]             set_we,
	input  wire logic [gpf_pkg::NUM_PINS-1:0]              clr_wdata,
	input  wire logic [gpf_pkg::NUM_PORTS-1:0]             clr_we,
	input  wire logic                                      dbgcfg_we,
	input  wire logic                                      ext_reg_en_wdata,
	input  wire logic                                      debug_dis_wdata,
	input  wire logic                                      dbg_pwrup_req,
	input  wire logic                                      dbg_sw_mode,
	input  wire logic                                      dbg_swdio_out,
	input  wire logic                                      dbg_swdio_oe,
	input  wire logic                                      dbg_tdo,
	input  wire logic                                      reg_en,
	input  wire logic [gpf_pkg::NUM_PINS-1:0]              alt_out,
	input  wire logic [gpf_pkg::NUM_PINS-1:0]              pad_in,
	output var  logic [gpf_pkg::NUM_PINS-1:0]              pad_out,
	output var  logic [gpf_pkg::NUM_PINS-1:0]              pad_oe,
	output var  logic [gpf_pkg::NUM_PINS-1:0]              pull_up_en,
	output var  logic [gpf_pkg::NUM_PINS-1:0]              pull_down_en,
	output var  logic [gpf_pkg::NUM_PINS*gpf_pkg::CFG_WIDTH-1:0] pin_config_regs,
	output var  logic [gpf_pkg::NUM_PINS-1:0]              port_output_reg,
	output var  logic [gpf_pkg::NUM_PINS-1:0]              port_input_reg,
	output var  logic [gpf_pkg::NUM_PINS-1:0]              periph_in,
	output var  logic                                      ext_regulator_enable_bit,
	output var  logic                                      debug_disable_bit,
	output var  logic                                      forced_debug_flag,
	output var  logic                                      boot_strap_status_bit,
	output var  logic                                      boot_monitor_sel,
	output var  logic                                      boot_done,
	output var  logic                                      debug_port_dbg_trst,
	output var  logic                                      debug_port_dbg_tdi,
	output var  logic                                      debug_port_dbg_tms,
	output var  logic                                      debug_port_swdio_in
);

	// ------------------------------------------------------------
	// Boot strap sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		BOOT_WAIT = 3'b001,
		BOOT_SAMP = 3'b010,
		BOOT_DONE = 3'b100
	} gpf_boot_type;

	gpf_boot_type             boot_state_r;
	logic [STARTUP_CNT_W-1:0] startup_cnt_r;
	logic [NUM_PINS-1:0]      pin_sync;
	logic [2:0]               dbg_sync;
	logic                     pwrup_s;
	logic                     swmode_s;
	logic                     osc_s;
	logic                     osc_d_r;
	logic                     osc_rise;
	logic                     strap_en_r;
	logic                     debug_on;
	logic [NUM_PINS-1:0]      cell_out;
	logic [NUM_PINS-1:0]      cell_oe;
	logic [NUM_PINS-1:0]      cell_pu;
	logic [NUM_PINS-1:0]      cell_pd;
	logic [NUM_PINS-1:0]      cell_din;

	localparam logic [STARTUP_CNT_W-1:0] STARTUP_LAST =
		STARTUP_CNT_W'(STARTUP_CLKS - 1);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	gpf_sync2 #(.WIDTH(NUM_PINS)) u_pin_sync (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.async_in (pad_in),
		.sync_out (pin_sync)
	);

	gpf_sync2 #(.WIDTH(3)) u_dbg_sync (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.async_in ({dbg_pwrup_req, dbg_sw_mode, osc_clk_tick}),
		.sync_out (dbg_sync)
	);

	assign pwrup_s  = dbg_sync[2];
	assign swmode_s = dbg_sync[1];
	assign osc_s    = dbg_sync[0];
	assign osc_rise = osc_s & ~osc_d_r;

	// ------------------------------------------------------------
	// Configuration and output registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			pin_config_regs <= {NUM_PINS{CFG_RESET}};
		else
			for (int p = 0; p < NUM_PORTS; p++)
				if (cfg_we[p])
					pin_config_regs[p*32 +: 32] <= cfg_wdata[p*32 +: 32];
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			port_output_reg <= '0;
		else
			for (int p = 0; p < NUM_PORTS; p++)
			begin
				if (out_we[p])
					port_output_reg[p*8 +: 8] <= out_wdata[p*8 +: 8];
				else if (set_we[p] || clr_we[p])
					port_output_reg[p*8 +: 8] <=
						(port_output_reg[p*8 +: 8] | ({8{set_we[p]}} & set_wdata[p*8 +: 8]))
						& ~({8{clr_we[p]}} & clr_wdata[p*8 +: 8]);
			end
	end

	// ------------------------------------------------------------
	// Debug configuration and status
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ext_regulator_enable_bit <= EXT_REG_EN_RESET;
			debug_disable_bit        <= DEBUG_DIS_RESET;
		end
		else if (dbgcfg_we)
		begin
			ext_regulator_enable_bit <= ext_reg_en_wdata;
			if (!debug_dis_wdata)
				debug_disable_bit <= 1'b0;
			else if (!pwrup_s)
				debug_disable_bit <= 1'b1;
		end
		else if (forced_debug_flag)
			debug_disable_bit <= 1'b0;
	end

	// Probe active at reset release reclaims the interface
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			forced_debug_flag <= 1'b0;
		else if (boot_state_r == BOOT_WAIT && startup_cnt_r == '0 && osc_rise
			&& pwrup_s && debug_disable_bit)
			forced_debug_flag <= 1'b1;
	end

	assign debug_on = ~debug_disable_bit | forced_debug_flag;

	// ------------------------------------------------------------
	// Boot strap sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			osc_d_r <= 1'b0;
		else
			osc_d_r <= osc_s;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			strap_en_r <= 1'b0;
		else if (boot_state_r == BOOT_WAIT)
			strap_en_r <= strap_reset;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			boot_state_r  <= BOOT_WAIT;
			startup_cnt_r <= '0;
		end
		else
			case (boot_state_r)
				BOOT_WAIT:
					if (osc_rise)
					begin
						if (startup_cnt_r == STARTUP_LAST)
							boot_state_r <= BOOT_SAMP;
						else
							startup_cnt_r <= startup_cnt_r + 1'b1;
					end
				BOOT_SAMP: boot_state_r <= BOOT_DONE;
				BOOT_DONE: boot_state_r <= BOOT_DONE;
				default:   boot_state_r <= BOOT_WAIT;
			endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			boot_strap_status_bit <= BOOT_STAT_RESET;
		else if (boot_state_r == BOOT_SAMP && strap_en_r)
			boot_strap_status_bit <= pin_sync[PIN_BOOT];
	end

	assign boot_monitor_sel = ~boot_strap_status_bit;
	assign boot_done        = (boot_state_r == BOOT_DONE);

	// ------------------------------------------------------------
	// Per-pin mode cells
	// ------------------------------------------------------------
	for (genvar i = 0; i < NUM_PINS; i++)
	begin : g_pin
		gpf_pin_cell u_cell (
			.cfg          (pin_config_regs[i*CFG_WIDTH +: CFG_WIDTH]),
			.out_bit      (port_output_reg[i]),
			.alt_bit      (alt_out[i]),
			.pin_sync     (pin_sync[i]),
			.pad_out      (cell_out[i]),
			.pad_oe       (cell_oe[i]),
			.pull_up_en   (cell_pu[i]),
			.pull_down_en (cell_pd[i]),
			.din          (cell_din[i])
		);
	end

	// ------------------------------------------------------------
	// Forced function overrides
	// ------------------------------------------------------------
	always_comb
	begin
		pad_out      = cell_out;
		pad_oe       = cell_oe;
		pull_up_en   = cell_pu;
		pull_down_en = cell_pd;
		if (ext_regulator_enable_bit)
		begin
			pad_out[PIN_REG_EN]      = 1'b0;
			pad_oe[PIN_REG_EN]       = ~reg_en;
			pull_up_en[PIN_REG_EN]   = 1'b0;
			pull_down_en[PIN_REG_EN] = 1'b0;
		end
		if (boot_state_r != BOOT_DONE && (strap_en_r || strap_reset))
		begin
			pad_oe[PIN_BOOT]       = 1'b0;
			pull_up_en[PIN_BOOT]   = 1'b1;
			pull_down_en[PIN_BOOT] = 1'b0;
		end
		if (debug_on)
		begin
			pad_oe[PIN_TRST]       = 1'b0;
			pull_up_en[PIN_TRST]   = 1'b1;
			pull_down_en[PIN_TRST] = 1'b0;
			pad_out[PIN_TDO]       = dbg_tdo;
			pad_oe[PIN_TDO]        = 1'b1;
			pull_up_en[PIN_TDO]    = 1'b0;
			pull_down_en[PIN_TDO]  = 1'b0;
			pad_oe[PIN_TDI]        = 1'b0;
			pull_up_en[PIN_TDI]    = 1'b1;
			pull_down_en[PIN_TDI]  = 1'b0;
			pull_down_en[PIN_TMS]  = 1'b0;
			if (swmode_s)
			begin
				pad_out[PIN_TMS]    = dbg_swdio_out;
				pad_oe[PIN_TMS]     = dbg_swdio_oe;
				pull_up_en[PIN_TMS] = 1'b0;
			end
			else
			begin
				pad_oe[PIN_TMS]     = 1'b0;
				pull_up_en[PIN_TMS] = 1'b1;
			end
		end
	end

	assign periph_in           = cell_din;
	assign debug_port_dbg_trst = pin_sync[PIN_TRST];
	assign debug_port_dbg_tdi  = pin_sync[PIN_TDI];
	assign debug_port_dbg_tms  = pin_sync[PIN_TMS];
	assign debug_port_swdio_in = pin_sync[PIN_TMS];

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			port_input_reg <= '0;
		else
			port_input_reg <= cell_din;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_samp;
		boot_state_r == BOOT_SAMP;
	endsequence

	AST_REGEN_OD: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ext_regulator_enable_bit |-> pad_out[PIN_REG_EN] == 1'b0 && pad_oe[PIN_REG_EN] == ~reg_en)
		else $error("regulator pin not forced");
	AST_DBG_DIS_BLOCK: assert property (@(posedge clk_sys) disable iff (!reset_n)
		dbgcfg_we && debug_dis_wdata && pwrup_s && !debug_disable_bit |=> !debug_disable_bit)
		else $error("debug disable set while active");
	AST_TDO_FORCED: assert property (@(posedge clk_sys) disable iff (!reset_n)
		debug_on |-> pad_oe[PIN_TDO] && pad_out[PIN_TDO] == dbg_tdo)
		else $error("tdo not forced");
	AST_ANALOG_IN: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pin_config_regs[35:32] == CFG_ANALOG |=> port_input_reg[8])
		else $error("analog input not one");
	AST_PULL_SEL: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pin_config_regs[43:40] == CFG_IN_PULL
		|-> cell_pu[10] == port_output_reg[10] && cell_pd[10] != port_output_reg[10])
		else $error("pull select wrong");
	AST_SET_BIT: assert property (@(posedge clk_sys) disable iff (!reset_n)
		set_we[1] && !out_we[1] && !clr_we[1]
		|=> (port_output_reg[15:8] & $past(set_wdata[15:8])) == $past(set_wdata[15:8]))
		else $error("set write lost");
	AST_CLR_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clr_we[1] && !out_we[1] && !set_we[1]
		|=> port_output_reg[15:8] == ($past(port_output_reg[15:8]) & ~$past(clr_wdata[15:8])))
		else $error("clear write wrong");
	AST_BOOT_CAP: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_samp ##0 strap_en_r |=> boot_strap_status_bit == $past(pin_sync[PIN_BOOT]) ##1 boot_done)
		else $error("strap not captured");
	AST_OD_OUT: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pin_config_regs[51:48] == CFG_OUT_OD |-> pad_oe[12] == ~port_output_reg[12])
		else $error("open drain wrong");

endmodule

`default_nettype wire

// File: rtl/gpf_pkg.sv
package gpf_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int NUM_PORTS  = 3;
	localparam int PORT_WIDTH = 8;
	localparam int NUM_PINS   = NUM_PORTS * PORT_WIDTH;
	localparam int CFG_WIDTH  = 4;

	// ------------------------------------------------------------
	// Configuration codes
	// ------------------------------------------------------------
	localparam logic [3:0] CFG_ANALOG   = 4'h0;
	localparam logic [3:0] CFG_IN_FLOAT = 4'h4;
	localparam logic [3:0] CFG_IN_PULL  = 4'h8;
	localparam logic [3:0] CFG_OUT_PP   = 4'h1;
	localparam logic [3:0] CFG_OUT_OD   = 4'h5;
	localparam logic [3:0] CFG_ALT_PP   = 4'h9;
	localparam logic [3:0] CFG_ALT_OD   = 4'hD;
	localparam logic [3:0] CFG_RESET    = CFG_IN_FLOAT;

	// ------------------------------------------------------------
	// Pin indices of forced functions (port * 8 + bit)
	// ------------------------------------------------------------
	localparam int PIN_REG_EN = 7;
	localparam int PIN_BOOT   = 5;
	localparam int PIN_TRST   = 16;
	localparam int PIN_TDO    = 18;
	localparam int PIN_TDI    = 19;
	localparam int PIN_TMS    = 20;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic       EXT_REG_EN_RESET = 1'b1;
	localparam logic       DEBUG_DIS_RESET  = 1'b0;
	localparam logic       BOOT_STAT_RESET  = 1'b1;
	localparam int         STARTUP_OSC_CLKS = 512;
	localparam int         STARTUP_CNT_W    = 10;

endpackage

// File: rtl/gpf_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module gpf_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// ------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_r   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

`default_nettype wire

// File: rtl/gpf_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module gpf_pin_cell
	import gpf_pkg::*;
(
	input  wire logic [gpf_pkg::CFG_WIDTH-1:0] cfg,
	input  wire logic                          out_bit,
	input  wire logic                          alt_bit,
	input  wire logic                          pin_sync,
	output var  logic                          pad_out,
	output var  logic                          pad_oe,
	output var  logic                          pull_up_en,
	output var  logic                          pull_down_en,
	output var  logic                          din
);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	always_comb
	begin
		pad_out      = 1'b0;
		pad_oe       = 1'b0;
		pull_up_en   = 1'b0;
		pull_down_en = 1'b0;
		din          = pin_sync;
		case (cfg)
			CFG_ANALOG:   din = 1'b1;
			CFG_IN_FLOAT: ;
			CFG_IN_PULL:
			begin
				pull_up_en   = out_bit;
				pull_down_en = ~out_bit;
			end
			CFG_OUT_PP:
			begin
				pad_out = out_bit;
				pad_oe  = 1'b1;
			end
			CFG_OUT_OD:
			begin
				pad_out = 1'b0;
				pad_oe  = ~out_bit;
			end
			CFG_ALT_PP:
			begin
				pad_out = alt_bit;
				pad_oe  = 1'b1;
			end
			CFG_ALT_OD:
			begin
				pad_out = 1'b0;
				pad_oe  = ~alt_bit;
			end
			default: ;
		endcase
	end

endmodule

`default_nettype wire

// File: testbench/gpf_pad_model.sv
`timescale 1ns/1ps
`default_nettype none

module gpf_pad_model
	import gpf_pkg::*;
(
	input  wire logic                         clk_sys,
	input  wire logic [gpf_pkg::NUM_PINS-1:0] pad_out,
	input  wire logic [gpf_pkg::NUM_PINS-1:0] pad_oe,
	input  wire logic [gpf_pkg::NUM_PINS-1:0] pull_up_en,
	input  wire logic [gpf_pkg::NUM_PINS-1:0] pull_down_en,
	input  wire logic [gpf_pkg::NUM_PINS-1:0] ext_en,
	input  wire logic [gpf_pkg::NUM_PINS-1:0] ext_val,
	output var  logic [gpf_pkg::NUM_PINS-1:0] pad_in
);
	import gpf_pkg::*;

	// ------------------------------------------------------------
	// Pin level resolution
	// ------------------------------------------------------------
	logic [NUM_PINS-1:0] last_r = '0;

	always_ff @(posedge clk_sys)
	begin
		last_r <= pad_in;
	end

	// External drive holds the strap low while the bench asks and the pad itself is not driving (pad_oe wins)
	always_comb
	begin
		for (int i = 0; i < NUM_PINS; i++)
		begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pull_up_en[i])
				pad_in[i] = 1'b1;
			else if (pull_down_en[i])
				pad_in[i] = 1'b0;
			else
				pad_in[i] = ~last_r[i];
		end
	end

endmodule

`default_nettype wire

// File: testbench/gpf_gpio_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module gpf_gpio_top_tb;
	import gpf_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int N_OSC = 8;
	logic                    clk_sys, reset_n, osc_clk_tick, strap_reset;
	logic [NUM_PINS*4-1:0]   cfg_wdata, pin_config_regs;
	logic [NUM_PORTS-1:0]    cfg_we, out_we, set_we, clr_we;
	logic [NUM_PINS-1:0]     out_wdata, set_wdata, clr_wdata, alt_out, pad_in;
	logic [NUM_PINS-1:0]     pad_out, pad_oe, pull_up_en, pull_down_en, ext_en, ext_val;
	logic [NUM_PINS-1:0]     port_output_reg, port_input_reg, periph_in;
	logic                    dbgcfg_we, ext_reg_en_wdata, debug_dis_wdata, dbg_pwrup_req;
	logic                    dbg_sw_mode, dbg_swdio_out, dbg_swdio_oe, dbg_tdo, reg_en;
	logic                    ext_regulator_enable_bit, debug_disable_bit, forced_debug_flag;
	logic                    boot_strap_status_bit, boot_monitor_sel, boot_done;
	logic                    dbg_trst, dbg_tdi, dbg_tms, swdio_in;
	int                      fails, tests_run;

	gpf_gpio_top #(.STARTUP_CLKS(N_OSC)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.osc_clk_tick(osc_clk_tick), .strap_reset(strap_reset), .cfg_wdata(cfg_wdata),
		.cfg_we(cfg_we), .out_wdata(out_wdata), .out_we(out_we), .set_wdata(set_wdata),
		.set_we(set_we), .clr_wdata(clr_wdata), .clr_we(clr_we), .dbgcfg_we(dbgcfg_we),
		.ext_reg_en_wdata(ext_reg_en_wdata), .debug_dis_wdata(debug_dis_wdata),
		.dbg_pwrup_req(dbg_pwrup_req), .dbg_sw_mode(dbg_sw_mode),
		.dbg_swdio_out(dbg_swdio_out), .dbg_swdio_oe(dbg_swdio_oe), .dbg_tdo(dbg_tdo),
		.reg_en(reg_en), .alt_out(alt_out), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
		.pin_config_regs(pin_config_regs), .port_output_reg(port_output_reg),
		.port_input_reg(port_input_reg), .periph_in(periph_in),
		.ext_regulator_enable_bit(ext_regulator_enable_bit),
		.debug_disable_bit(debug_disable_bit), .forced_debug_flag(forced_debug_flag),
		.boot_strap_status_bit(boot_strap_status_bit), .boot_monitor_sel(boot_monitor_sel),
		.boot_done(boot_done), .debug_port_dbg_trst(dbg_trst), .debug_port_dbg_tdi(dbg_tdi),
		.debug_port_dbg_tms(dbg_tms), .debug_port_swdio_in(swdio_in));

	gpf_pad_model pads (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
		.pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
		.ext_val(ext_val), .pad_in(pad_in));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic chk_vec(input logic [95:0] got, input logic [95:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t %s got %h", $time, msg, got);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cfg_wr(input int p, input logic [31:0] d);
		cfg_wdata[32*p+:32] = d;
		cfg_we[p] = 1'b1;
		step(1);
		cfg_we = '0;
	endtask

	task automatic port_wr(input int kind, input int p, input logic [7:0] d);
		case (kind)
			0: begin out_wdata[8*p+:8] = d; out_we[p] = 1'b1; end
			1: begin set_wdata[8*p+:8] = d; set_we[p] = 1'b1; end
			default: begin clr_wdata[8*p+:8] = d; clr_we[p] = 1'b1; end
		endcase
		step(1);
		out_we = '0;
		set_we = '0;
		clr_we = '0;
	endtask

	task automatic dbg_wr(input logic ext, input logic dis);
		ext_reg_en_wdata = ext;
		debug_dis_wdata = dis;
		dbgcfg_we = 1'b1;
		step(1);
		dbgcfg_we = 1'b0;
	endtask

	task automatic run_boot(input logic exp_stat);
		int i;
		repeat (N_OSC - 1)
		begin
			osc_clk_tick = 1'b1;
			step(3);
			osc_clk_tick = 1'b0;
			step(3);
		end
		chk_bit(pull_up_en[PIN_BOOT], strap_reset, "strap pull-up wrong");
		chk_bit(boot_done, 1'b0, "boot done early");
		osc_clk_tick = 1'b1;
		step(3);
		osc_clk_tick = 1'b0;
		for (i = 0; i < 100 && boot_done !== 1'b1; i++)
			step(1);
		if (boot_done !== 1'b1)
		begin
			fails++;
			$display("[FAIL] %0t boot never done", $time);
			results();
		end
		else
		begin
			chk_bit(boot_strap_status_bit, exp_stat, "strap status");
			chk_bit(boot_monitor_sel, ~exp_stat, "monitor select");
			chk_bit(pull_up_en[PIN_BOOT], 1'b0, "strap pin not floating");
		end
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		step(5);
		reset_n = 1'b1;
		step(1);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_state();
		chk_vec(pin_config_regs, {NUM_PINS{CFG_RESET}}, "configs after reset");
		chk_bit(ext_regulator_enable_bit, 1'b1, "regulator bit");
		chk_bit(debug_disable_bit, 1'b0, "debug disable bit");
		chk_bit(forced_debug_flag, 1'b0, "forced debug flag");
		chk_vec({pad_oe[PIN_REG_EN], pad_out[PIN_REG_EN]}, 2'b10, "reg enable sink");
		reg_en = 1'b1;
		dbg_tdo = 1'b1;
		step(1);
		chk_bit(pad_oe[PIN_REG_EN], 1'b0, "reg enable release");
		chk_vec({pad_oe[PIN_TDO], pad_out[PIN_TDO]}, 2'b11, "test data out");
		chk_vec({dbg_trst, dbg_tdi, dbg_tms, swdio_in}, 4'hF, "debug inputs");
		chk_vec({pull_up_en[PIN_TRST], pull_up_en[PIN_TDI], pull_up_en[PIN_TMS]},
			3'b111, "debug pulls");
		reg_en = 1'b0;
	endtask

	task automatic t_modes();
		cfg_wr(1, 32'h8D951840);
		port_wr(0, 1, 8'h1C);
		alt_out[14:13] = 2'b10;
		ext_en[12:8] = 5'h13;
		ext_val[12:8] = 5'h02;
		step(4);
		chk_vec(pad_oe[15:8], 8'h28, "drivers by mode");
		chk_vec(pull_up_en[15:8], 8'h04, "pull-ups by mode");
		chk_vec(pull_down_en[15:8], 8'h80, "pull-downs by mode");
		chk_vec({pad_out[11], pad_out[13]}, 2'b10, "driven levels");
		chk_vec({port_input_reg[8], periph_in[8]}, 2'b11, "analog reads one");
		chk_vec({port_input_reg[9], periph_in[9]}, 2'b11, "input follows pin");
		chk_vec(port_input_reg[13:11], 3'b001, "outputs read back pin");
		chk_bit(port_output_reg[12], 1'b1, "output reg kept");
		port_wr(1, 1, 8'h81);
		port_wr(2, 1, 8'h14);
		chk_vec(port_output_reg[15:8], 8'h89, "set and clear");
		chk_vec({pull_up_en[15], pull_down_en[15]}, 2'b10, "pull swaps");
		port_wr(0, 1, 8'h00);
		port_wr(2, 1, 8'h00);
		chk_vec(port_output_reg[15:8], 8'h00, "stale set data applied");
	endtask

	task automatic t_debug();
		dbg_pwrup_req = 1'b1;
		step(3);
		dbg_wr(1'b1, 1'b1);
		chk_bit(debug_disable_bit, 1'b0, "disable taken while active");
		dbg_pwrup_req = 1'b0;
		step(3);
		dbg_wr(1'b0, 1'b1);
		chk_vec({debug_disable_bit, ext_regulator_enable_bit}, 2'b10, "debug cfg");
		chk_vec({pull_up_en[PIN_TRST], pad_oe[PIN_TDO], pull_up_en[PIN_TMS]},
			3'b000, "debug pins freed");
		chk_bit(pad_oe[PIN_REG_EN], 1'b0, "reg enable pin freed");
	endtask

	task automatic t_second_reset();
		strap_reset = 1'b0;
		dbg_sw_mode = 1'b1;
		dbg_swdio_oe = 1'b1;
		dbg_swdio_out = 1'b1;
		do_reset();
		chk_vec({debug_disable_bit, ext_regulator_enable_bit}, 2'b01, "reset dbg");
		step(3);
		chk_vec({pad_oe[PIN_TMS], pad_out[PIN_TMS]}, 2'b11, "serial data drive");
		dbg_swdio_oe = 1'b0;
		step(1);
		chk_vec({pad_oe[PIN_TMS], pull_up_en[PIN_TMS]}, 2'b00, "serial data input");
		run_boot(1'b1);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		fails = 0;
		tests_run = 0;
		{reset_n, osc_clk_tick, cfg_wdata, cfg_we, out_wdata, out_we} = '0;
		{set_wdata, set_we, clr_wdata, clr_we, dbgcfg_we, ext_reg_en_wdata} = '0;
		{debug_dis_wdata, dbg_pwrup_req, dbg_sw_mode, dbg_swdio_out, dbg_swdio_oe} = '0;
		{dbg_tdo, reg_en, alt_out, ext_val} = '0;
		strap_reset = 1'b1;
		ext_en = '0;
		ext_en[PIN_BOOT] = 1'b1;
		do_reset();
		t_reset_state();
		run_boot(1'b0);
		t_modes();
		t_debug();
		t_second_reset();
		results();
	end

endmodule

`default_nettype wire
